//--- block_code_frame_encoder.sv
// Block-code encoder end, clocked by the link bit clock
//
// Summary of operation
// - Eight-bit frames in, eight-bit frames out
// - One to three upper bits become checks
// - Bit 0 carries frame sync both ways
// - Message bits 1 to 4 pass unchanged
// - Source sends zeros in bits 5 to 7
// - Output bits 5 to 7 hold checks
// - Parity in bit 5, bits 6-7 zero
// - Hamming and cyclic fill bits 5-7
// - Selector: even, Hamming, variant third code
// - Set-up code passes frames unaltered
// - Frame boundaries from supplied sync
// - No sync output generated here
// - Sync bit 0 copied unchanged
// - Source drives clock, data and sync
// - Bit clock in phase with data
// - Bit clock near 2kHz, below 8kHz
// - TDM streams handled like single streams
// - TDM sources 4-bit, shared bit clock
// - Sync high one bit at bit 0
`timescale 1ns/100ps
`default_nettype none
module block_code_frame_encoder
    import block_code_pkg::*;
#(
    parameter variant_e VARIANT = VARIANT_SETUP
) (
    block_code_link.encoder link,
    input wire logic rst_n,
    input wire logic [1:0] code_sel,
    output logic [7:0] last_frame
);
    // ------------------------------------------------------------
    // Input shift and frame capture
    // ------------------------------------------------------------
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [7:0] next_in;
    logic [7:0] coded;
    logic [3:0] msg;
    logic [2:0] checks;
    logic parity;
    logic [1:0] sel_sync1;
    logic [1:0] sel;
    logic rst_sync1;
    logic rst_sync2;

    // Data arrives MSB first; sync marks bit 0, the frame's last bit
    assign next_in = {shift_in[6:0], link.data_in};
    assign msg = next_in[MSG_MSB:MSG_LSB];
    assign parity = ^msg;

    // Reset is made on the system clock; two flops move it onto the bit clock
    always_ff @(posedge link.bit_clk) begin
        rst_sync1 <= rst_n;
        rst_sync2 <= rst_sync1;
    end

    // Selector is a slow switch; synchronised into the bit-clock domain
    always_ff @(posedge link.bit_clk) begin
        if (!rst_sync2) begin
            sel_sync1 <= 2'h1;
            sel <= 2'h1;
        end else begin
            sel_sync1 <= code_sel;
            sel <= sel_sync1;
        end
    end

    // ------------------------------------------------------------
    // Check-bit selection
    // ------------------------------------------------------------
    always_comb begin
        coded = next_in;
        checks = 3'h0;
        unique case (sel)
            CODE_2: begin
                checks = hamming_check(msg);
                coded = {checks, next_in[MSG_MSB:SYNC_POS]};
            end
            CODE_3: begin
                if (VARIANT == VARIANT_ODD) begin
                    checks = {2'h0, ~parity};
                    coded = {checks, next_in[MSG_MSB:SYNC_POS]};
                end else if (VARIANT == VARIANT_CYCLIC) begin
                    checks = cyclic_check(msg);
                    coded = {checks, next_in[MSG_MSB:SYNC_POS]};
                end
            end
            default: begin
                checks = {2'h0, parity};
                coded = {checks, next_in[MSG_MSB:SYNC_POS]};
            end
        endcase
    end

    // ------------------------------------------------------------
    // Frame registers; sync reload gives a fixed one-frame lag
    // ------------------------------------------------------------
    always_ff @(posedge link.bit_clk) begin
        if (!rst_sync2) begin
            shift_in <= FRAME_RESET;
            shift_out <= FRAME_RESET;
            last_frame <= FRAME_RESET;
        end else begin
            shift_in <= next_in;
            if (link.frame_sync) begin
                shift_out <= coded;
                last_frame <= coded;
            end else begin
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // Only data leaves; no sync output exists
    assign link.coded_out = shift_out[CHECK_MSB];
endmodule
`default_nettype wire

//--- block_code_frame_encoder_tb.sv
// Bench joining frame source and encoder over the link
`timescale 1ns/100ps
`default_nettype none
module block_code_frame_encoder_tb
    import block_code_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic enc_rst_n = 1'b0;
    logic [1:0] code_sel = 2'h2;
    logic [3:0] message = 4'hb;
    // Bit clock divided far below a real link's period so three codes fit a short run
    localparam int BENCH_HALF = 8;
    // About 512 cycles (four frames) per code at this rate; the ceiling is over twice the whole run
    localparam int TIMEOUT_CYCLES = 4000;
    logic [7:0] last_frame;
    logic [7:0] last_frame_setup;
    logic [7:0] last_frame_cyclic;
    logic [7:0] rx_frame;
    logic rx_valid;
    logic prev_sync;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    block_code_link link ();
    block_code_link link_setup ();
    block_code_link link_cyclic ();
    assign link_setup.bit_clk = link.bit_clk;
    assign link_setup.data_in = link.data_in;
    assign link_setup.frame_sync = link.frame_sync;
    assign link_cyclic.bit_clk = link.bit_clk;
    assign link_cyclic.data_in = link.data_in;
    assign link_cyclic.frame_sync = link.frame_sync;
    block_code_frame_source #(.HALF_CYCLES(BENCH_HALF)) u_block_code_frame_source (
        .clk(clk), .rst_n(rst_n), .message(message), .link(link.source),
        .rx_frame(rx_frame), .rx_valid(rx_valid));
    block_code_frame_encoder #(.VARIANT(VARIANT_SETUP)) u_block_code_frame_encoder_setup (
        .link(link_setup.encoder), .rst_n(enc_rst_n), .code_sel(code_sel),
        .last_frame(last_frame_setup));
    block_code_frame_encoder #(.VARIANT(VARIANT_CYCLIC)) u_block_code_frame_encoder_cyclic (
        .link(link_cyclic.encoder), .rst_n(enc_rst_n), .code_sel(code_sel),
        .last_frame(last_frame_cyclic));
    block_code_frame_encoder #(.VARIANT(VARIANT_ODD)) u_block_code_frame_encoder (
        .link(link.encoder), .rst_n(enc_rst_n), .code_sel(code_sel), .last_frame(last_frame));
    block_code_link_props u_block_code_link_props (.bit_clk(link.bit_clk),
        .data_in(link.data_in), .frame_sync(link.frame_sync), .coded_out(link.coded_out),
        .rst_n(enc_rst_n), .code_sel(code_sel));
    // ----------------------------------------
    // Clock, timeout and tasks
    // ----------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    // A stalled link or lost sync ends here as a failure
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            errors = errors + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_frame();
        @(negedge clk);
        while (rx_valid !== 1'b1) begin
            @(negedge clk);
        end
    endtask
    // Code changes only under encoder reset, so no frame mixes two codes
    task automatic run_code(input logic [1:0] code, input logic [3:0] m);
        logic [2:0] chk;
        logic [2:0] cyc;
        chk = (code == CODE_2) ? {m[1] ^ m[2] ^ m[3], m[0] ^ m[2] ^ m[3], m[0] ^ m[1] ^ m[3]}
            : {2'h0, (code == CODE_3) ^ (^m)};
        // Remainder of m(x)*x^3 modulo x^3+x+1
        cyc = {m[1] ^ m[2] ^ m[3], m[0] ^ m[1] ^ m[2], m[0] ^ m[2] ^ m[3]};
        @(negedge clk);
        enc_rst_n = 1'b0;
        code_sel = code;
        message = m;
        repeat (3) @(posedge link.bit_clk);
        @(negedge clk);
        enc_rst_n = 1'b1;
        repeat (3) wait_frame();
        prev_sync = rx_frame[0];
        wait_frame();
        check({rx_frame[7:1], 1'b0}, {chk, m, 1'b0});
        check({last_frame[7:1], 1'b0}, {chk, m, 1'b0});
        check({7'h00, rx_frame[0]}, {7'h00, ~prev_sync});
        if (code == CODE_3) begin
            check({last_frame_setup[7:1], 1'b0}, {3'h0, m, 1'b0});
            check({last_frame_cyclic[7:1], 1'b0}, {cyc, m, 1'b0});
        end
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        run_code(CODE_2, 4'hb);
        run_code(CODE_1, 4'h7);
        run_code(CODE_3, 4'h3);
        end_sim();
    end
endmodule
`default_nettype wire

//--- block_code_frame_source.sv
// Frame source end: makes bit clock, serial frames and sync pulse
`timescale 1ns/100ps
`default_nettype none
module block_code_frame_source
    import block_code_pkg::*;
#(
    parameter int HALF_CYCLES = BIT_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] message,
    block_code_link.source link,
    output logic [7:0] rx_frame,
    output logic rx_valid
);
    // ------------------------------------------------------------
    // Bit clock divider
    // ------------------------------------------------------------
    logic [15:0] half_cnt;
    logic bit_clk;
    logic [2:0] bit_idx;
    logic [7:0] tx_frame;
    logic [3:0] msg_hold;
    logic sync_bit;
    logic [7:0] rx_shift;
    logic rx_s1;
    logic rx_s2;
    logic half_done;
    logic rise;

    assign half_done = (half_cnt == 16'(HALF_CYCLES - 1));
    assign rise = half_done && !bit_clk;

    // Data changes on the falling edge so rising edges sample mid-bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_cnt <= BIT_HALF_RESET;
            bit_clk <= 1'b0;
        end else begin
            half_cnt <= half_done ? BIT_HALF_RESET : half_cnt + 16'h0001;
            if (half_done) begin
                bit_clk <= ~bit_clk;
            end
        end
    end

    // ------------------------------------------------------------
    // Frame transmit, MSB first, upper bits zero
    // ------------------------------------------------------------
    logic fall;
    assign fall = half_done && bit_clk;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_idx <= BIT_CNT_RESET;
            msg_hold <= 4'h0;
            sync_bit <= 1'b0;
        end else if (fall) begin
            bit_idx <= bit_idx - 3'h1;
            if (bit_idx == 3'h0) begin
                msg_hold <= message;
                sync_bit <= ~sync_bit;
            end
        end
    end

    assign tx_frame = {3'h0, msg_hold, sync_bit};
    assign link.bit_clk = bit_clk;
    assign link.data_in = tx_frame[bit_idx];
    assign link.frame_sync = (bit_idx == 3'h0);

    // ------------------------------------------------------------
    // Returned coded stream, sampled at rising bit-clock edges
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            rx_shift <= FRAME_RESET;
            rx_frame <= FRAME_RESET;
            rx_valid <= 1'b0;
        end else begin
            rx_s1 <= link.coded_out;
            rx_s2 <= rx_s1;
            rx_valid <= 1'b0;
            if (rise) begin
                rx_shift <= {rx_shift[6:0], rx_s2};
                // Last coded bit lands with the next frame's sync bit
                if (bit_idx == 3'h0) begin
                    rx_frame <= {rx_shift[6:0], rx_s2};
                    rx_valid <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- block_code_link.sv
// Serial link between frame source and block-code encoder
`timescale 1ns/100ps
`default_nettype none
interface block_code_link;
    logic bit_clk;
    logic data_in;
    logic frame_sync;
    logic coded_out;

    modport encoder (input bit_clk, input data_in, input frame_sync, output coded_out);
    modport source (output bit_clk, output data_in, output frame_sync, input coded_out);
endinterface
`default_nettype wire

//--- block_code_link_props.sv
// Checker for the block-code serial link
`timescale 1ns/100ps
`default_nettype none
module block_code_link_props
    import block_code_pkg::*;
(
    input wire logic bit_clk,
    input wire logic data_in,
    input wire logic frame_sync,
    input wire logic coded_out,
    input wire logic rst_n,
    input wire logic [1:0] code_sel
);
    // ----------------------------------------
    // Frames since reset
    // ----------------------------------------
    // Two syncs first, so no frame holds bits from the reset
    logic [1:0] seen;
    wire full = seen == 2'h2;
    always_ff @(posedge bit_clk) begin
        if (!rst_n) begin
            seen <= 2'h0;
        end else if (frame_sync && !full) begin
            seen <= seen + 2'h1;
        end
    end
    default clocking @(posedge bit_clk); endclocking
    default disable iff (!rst_n);
    a_sync_one_bit: assert property (
        frame_sync |=> !frame_sync) else $error("sync wider than one bit");
    a_sync_period: assert property (
        frame_sync |=> !frame_sync [*7] ##1 frame_sync) else $error("frame not eight bits");
    a_input_zeros: assert property (
        frame_sync |=> !data_in [*3]) else $error("upper input bits not zero");
    a_bits_copied: assert property (
        full && frame_sync |-> ##4 (coded_out == $past(data_in, 8)) [*5])
        else $error("message or sync bit altered");
    a_parity_even: assert property (
        full && frame_sync && code_sel == CODE_1 |=> !coded_out ##1 !coded_out
        ##1 (coded_out == ($past(data_in, 4) ^ $past(data_in, 5) ^ $past(data_in, 6)
        ^ $past(data_in, 7)))) else $error("even parity frame wrong");
    a_parity_odd: assert property (
        full && frame_sync && code_sel == CODE_3 |=> !coded_out ##1 !coded_out
        ##1 (coded_out != ($past(data_in, 4) ^ $past(data_in, 5) ^ $past(data_in, 6)
        ^ $past(data_in, 7)))) else $error("odd parity frame wrong");
    a_hamming_bits: assert property (
        full && frame_sync && code_sel == CODE_2
        |=> (coded_out == ($past(data_in, 3) ^ $past(data_in, 4) ^ $past(data_in, 5)))
        ##1 (coded_out == ($past(data_in, 3) ^ $past(data_in, 5) ^ $past(data_in, 6)))
        ##1 (coded_out == ($past(data_in, 4) ^ $past(data_in, 5) ^ $past(data_in, 7))))
        else $error("hamming check bits wrong");
    // Reset reaches the encoder logic through two flops
    a_reset_quiet: assert property (
        disable iff (1'b0) !rst_n [*3] |=> !coded_out) else $error("output active in reset");
endmodule
`default_nettype wire

//--- block_code_pkg.sv
// Shared constants and types for the serial block-code frame encoder
`default_nettype none
package block_code_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 8;
    localparam int SYNC_POS = 0;
    localparam int MSG_LSB = 1;
    localparam int MSG_MSB = 4;
    localparam int CHECK_LSB = 5;
    localparam int CHECK_MSB = 7;
    localparam logic [2:0] BIT_CNT_RESET = 3'h7;
    localparam logic [7:0] FRAME_RESET = 8'h00;

    // ------------------------------------------------------------
    // Code selector and build variants
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CODE_1 = 2'h1,
        CODE_2 = 2'h2,
        CODE_3 = 2'h3
    } code_sel_e;

    typedef enum logic [1:0] {
        VARIANT_SETUP = 2'h0,
        VARIANT_ODD = 2'h1,
        VARIANT_CYCLIC = 2'h2
    } variant_e;

    // ------------------------------------------------------------
    // Bit clock timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 10_000_000;
    localparam int BIT_RATE_HZ = 2_000;
    localparam int BIT_MAX_HZ = 8_000;
    // Half period of the derived bit clock, rounded down
    localparam int BIT_HALF_CYCLES = CLK_FREQ_HZ / (2 * BIT_RATE_HZ);
    localparam logic [15:0] BIT_HALF_RESET = 16'h0000;

    // Hamming (7,4): c0=d0^d1^d3, c1=d0^d2^d3, c2=d1^d2^d3
    function automatic logic [2:0] hamming_check(input logic [3:0] d);
        hamming_check = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
    endfunction

    // Cyclic (7,4), generator x^3+x+1, remainder of d(x)*x^3
    function automatic logic [2:0] cyclic_check(input logic [3:0] d);
        cyclic_check = {d[3] ^ d[2] ^ d[1], d[2] ^ d[1] ^ d[0], d[3] ^ d[2] ^ d[0]};
    endfunction
endpackage
`default_nettype wire
